// file: core/mc_rom.sv
// microcode sequence store with registered read data
module mc_rom import ooo_core_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [MC_ADDR_W-1:0] rd_addr,
  output logic [MC_WORD_W-1:0] rd_word_r
);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_word_r <= MC_WORD_RST;
    end else begin
      rd_word_r <= MC_ROM_IMAGE[{rd_addr, 2'b00} +: MC_WORD_W];
    end
  end
endmodule

// file: core/ooo_core.sv
// decode, rename, dispatch, branch recovery and in-order retirement
module ooo_core import ooo_core_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic fetch_valid,
  input wire logic [FETCH_BYTES-1:0][7:0] fetch_bytes,
  input wire logic [FETCH_BYTES-1:0] fetch_start,
  input wire logic [FETCH_BYTES-1:0] fetch_end,
  input wire logic [DATA_W-1:0] fetch_pc,
  input wire logic [DATA_W-1:0] fetch_pred_target,
  output logic fetch_ready_r,
  input wire logic [NUM_PORTS-1:0] port_free,
  output logic [NUM_PORTS-1:0] disp_valid_r,
  output logic [NUM_PORTS-1:0][3:0] disp_tag_r,
  output logic [NUM_PORTS-1:0][DATA_W-1:0] disp_a_r,
  output logic [NUM_PORTS-1:0][DATA_W-1:0] disp_b_r,
  output logic [NUM_PORTS-1:0][1:0] disp_width_r,
  input wire logic [NUM_PORTS-1:0] wb_valid,
  input wire logic [NUM_PORTS-1:0][3:0] wb_tag,
  input wire logic [NUM_PORTS-1:0][DATA_W-1:0] wb_data,
  input wire logic wb_br_taken,
  input wire logic wb_blocked,
  input wire logic mem_retry,
  output logic redirect_valid_r,
  output logic [DATA_W-1:0] redirect_target_r,
  input wire logic mem_st_ready,
  output logic mem_st_valid_r,
  output logic [DATA_W-1:0] mem_st_addr_r,
  output logic [DATA_W-1:0] mem_st_data_r,
  output logic [1:0] mem_st_width_r,
  output logic [1:0] retire_count_r,
  input wire logic [2:0] dbg_reg,
  output logic [DATA_W-1:0] dbg_val_r
);
  // front end state
  logic [NUM_DEC-1:0] slot_v_r;
  logic [7:0] slot_op_r [NUM_DEC];
  logic [7:0] slot_rg_r [NUM_DEC];
  word_t slot_ft_r [NUM_DEC];
  word_t slot_pred_r;
  logic [1:0] step_r;
  logic [MC_ADDR_W-1:0] mc_addr_q_r;
  logic mc_q_v_r;
  logic [MC_WORD_W-1:0] mc_word;
  // pool, rename table, committed file
  logic p_valid_r [POOL_DEPTH];
  logic p_done_r [POOL_DEPTH];
  logic p_disp_r [POOL_DEPTH];
  logic p_susp_r [POOL_DEPTH];
  logic p_wake_r [POOL_DEPTH];
  logic p_a_rdy_r [POOL_DEPTH];
  logic p_b_rdy_r [POOL_DEPTH];
  logic p_dst_v_r [POOL_DEPTH];
  ukind_t p_kind_r [POOL_DEPTH];
  lreg_t p_ldst_r [POOL_DEPTH];
  logic [1:0] p_width_r [POOL_DEPTH];
  pidx_t p_a_tag_r [POOL_DEPTH];
  pidx_t p_b_tag_r [POOL_DEPTH];
  word_t p_a_val_r [POOL_DEPTH];
  word_t p_b_val_r [POOL_DEPTH];
  word_t p_res_r [POOL_DEPTH];
  word_t p_ft_r [POOL_DEPTH];
  word_t p_pred_r [POOL_DEPTH];
  ptr_t head_r;
  ptr_t tail_r;
  logic map_valid_r [LREGS];
  pidx_t map_tag_r [LREGS];
  word_t arch_r [LREGS];
  word_t st_addr_r;

  // k-th start mark in the fetch block, as {found, position}
  function automatic logic [4:0] nth_start(input logic [15:0] m,
                                           input int n);
    logic [4:0] o;
    int seen;
    o = 5'h00;
    seen = 0;
    for (int i = 0; i < FETCH_BYTES; i++) begin
      if (m[i] && !o[4]) begin
        if (seen == n) begin
          o = {1'b1, 4'(i)};
        end
        seen = seen + 1;
      end
    end
    return o;
  endfunction

  // source lookup: {ready, tag, value}, catching same-cycle results
  function automatic logic [20:0] resolve(input lreg_t r);
    logic [20:0] o;
    pidx_t t;
    t = map_tag_r[r];
    o = {1'b1, 4'h0, arch_r[r]};
    if (map_valid_r[r]) begin
      o = {p_done_r[t], t, p_res_r[t]};
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (wb_valid[p] && wb_tag[p] == t &&
            !(ukind_t'(p) == UK_LD && wb_blocked)) begin
          o = {1'b1, t, wb_data[p]};
        end
      end
    end
    return o;
  endfunction

  // three decoders in parallel
  logic [NUM_DEC-1:0] dec_ok;
  logic [7:0] dec_op [NUM_DEC];
  logic [7:0] dec_rg [NUM_DEC];
  word_t dec_ft [NUM_DEC];
  logic take;
  assign take = fetch_valid & fetch_ready_r;
  for (genvar g = 0; g < NUM_DEC; g++) begin : g_dec
    logic [4:0] hit;
    logic [3:0] nxt_pos;
    assign hit = nth_start(fetch_start, g);
    assign nxt_pos = hit[3:0] + 4'h1;
    // an instruction straddling the block end is dropped
    assign dec_ok[g] = hit[4] && hit[3:0] != 4'hF &&
                       fetch_end[nxt_pos];
    assign dec_op[g] = fetch_bytes[hit[3:0]];
    assign dec_rg[g] = fetch_bytes[nxt_pos];
    assign dec_ft[g] = fetch_pc + {12'h000, hit[3:0]} + INSTR_LEN;
  end

  // expansion of the oldest slot into one operation per clock
  logic [1:0] cur;
  logic [2:0] ik;
  logic [1:0] cnt;
  ukind_t uk;
  logic last;
  logic uop_ok;
  logic emit;
  logic full;
  logic microcode_sequencer;
  logic [MC_ADDR_W-1:0] mc_addr;
  ptr_t count;
  assign count = tail_r - head_r;
  assign full = count == POOL_FULL;
  assign cur = slot_v_r[0] ? 2'd0 : (slot_v_r[1] ? 2'd1 : 2'd2);
  assign ik = slot_op_r[cur][OP_KIND_LSB +: 3];
  assign cnt = slot_op_r[cur][OP_CNT_LSB +: 2];
  assign mc_addr = {cnt, step_r};
  always_comb begin
    uk = UK_ALU;
    last = 1'b1;
    uop_ok = 1'b1;
    case (ik)
      IK_ALU, IK_BR, IK_LD: begin
        uk = ik;
        last = step_r == cnt;
      end
      IK_ST: begin
        uk = (step_r == 2'd0) ? UK_STA : UK_STD;
        last = step_r == 2'd1;
      end
      IK_CPLX: begin
        // one bubble per step: the sequence store answers a cycle late
        uop_ok = mc_q_v_r && mc_addr_q_r == mc_addr;
        uk = mc_word[2:0];
        last = mc_word[MC_LAST_BIT];
      end
      default: begin
        uk = UK_ALU;
        last = 1'b1;
      end
    endcase
  end
  assign emit = slot_v_r[cur] & uop_ok & ~full & ~microcode_sequencer;

  mc_rom u_mc_rom (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .rd_addr(mc_addr),
    .rd_word_r(mc_word)
  );

  // rename of the emitted operation
  lreg_t src1;
  lreg_t src2;
  logic need_a;
  logic need_b;
  logic has_dst;
  logic [20:0] res_a;
  logic [20:0] res_b;
  assign src1 = slot_rg_r[cur][RG_SRC1_LSB +: 3];
  assign src2 = slot_op_r[cur][OP_SRC2_LSB +: 3];
  assign need_a = uk != UK_STD;
  assign need_b = uk == UK_ALU || uk == UK_BR || uk == UK_STD;
  assign has_dst = uk == UK_ALU || uk == UK_LD;
  always_comb begin
    res_a = resolve(src1);
    res_b = resolve(src2);
  end

  // branch resolution
  pidx_t br_tag;
  word_t br_actual;
  pidx_t br_off;
  assign br_tag = wb_tag[UK_BR];
  assign br_actual = wb_br_taken ? wb_data[UK_BR] : p_ft_r[br_tag];
  assign microcode_sequencer = wb_valid[UK_BR] && p_valid_r[br_tag] &&
               br_actual != p_pred_r[br_tag];
  assign br_off = br_tag - head_r[3:0];

  // scheduler: one grant per port
  logic [NUM_PORTS-1:0] gnt_v;
  pidx_t gnt_idx [NUM_PORTS];
  always_comb begin
    logic fo;
    logic fw;
    logic seen;
    pidx_t io;
    pidx_t iw;
    pidx_t ix;
    logic rdy;
    fo = 1'b0;
    fw = 1'b0;
    seen = 1'b0;
    io = 4'h0;
    iw = 4'h0;
    ix = 4'h0;
    rdy = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      fo = 1'b0;
      fw = 1'b0;
      seen = 1'b0;
      io = 4'h0;
      iw = 4'h0;
      for (int i = 0; i < POOL_DEPTH; i++) begin
        ix = head_r[3:0] + 4'(i);
        rdy = p_valid_r[ix] && !p_done_r[ix] && !p_disp_r[ix] &&
              !p_susp_r[ix] && p_a_rdy_r[ix] && p_b_rdy_r[ix];
        if (5'(i) < count && p_kind_r[ix] == ukind_t'(p)) begin
          if (ukind_t'(p) == UK_STA || ukind_t'(p) == UK_STD) begin
            // store halves strictly oldest first, never overtaking
            if (!seen && !p_done_r[ix] && !p_disp_r[ix]) begin
              seen = 1'b1;
              fo = rdy;
              io = ix;
            end
          end else begin
            if (rdy && !fo) begin
              fo = 1'b1;
              io = ix;
            end
            if (rdy && p_wake_r[ix] && !fw) begin
              fw = 1'b1;
              iw = ix;
            end
          end
        end
      end
      gnt_v[p] = (fo | fw) & port_free[p] & ~microcode_sequencer;
      gnt_idx[p] = fw ? iw : io;
    end
  end

  // retirement candidates in program order
  logic [1:0] ret_cnt;
  logic ret_std;
  logic ret_sta;
  pidx_t ret_idx [RET_WIDTH];
  always_comb begin
    logic go;
    ret_cnt = 2'd0;
    ret_std = 1'b0;
    ret_sta = 1'b0;
    go = 1'b1;
    for (int r = 0; r < RET_WIDTH; r++) begin
      ret_idx[r] = head_r[3:0] + 4'(r);
      if (go && 5'(r) < count && p_valid_r[ret_idx[r]] &&
          p_done_r[ret_idx[r]] &&
          (p_kind_r[ret_idx[r]] != UK_STD || mem_st_ready)) begin
        ret_cnt = ret_cnt + 2'd1;
        if (p_kind_r[ret_idx[r]] == UK_STA) begin
          ret_sta = 1'b1;
          go = 1'b0;
        end
        if (p_kind_r[ret_idx[r]] == UK_STD) begin
          ret_std = 1'b1;
          go = 1'b0;
        end
      end else begin
        go = 1'b0;
      end
    end
  end
  pidx_t ret_last;
  assign ret_last = head_r[3:0] + 4'(ret_cnt) - 4'h1;

  // front end registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      slot_v_r <= '0;
      step_r <= 2'd0;
      fetch_ready_r <= FETCH_READY_RST;
      slot_pred_r <= '0;
      mc_addr_q_r <= '0;
      mc_q_v_r <= 1'b0;
      for (int k = 0; k < NUM_DEC; k++) begin
        slot_op_r[k] <= 8'h00;
        slot_rg_r[k] <= 8'h00;
        slot_ft_r[k] <= '0;
      end
    end else begin
      mc_addr_q_r <= mc_addr;
      mc_q_v_r <= 1'b1;
      if (microcode_sequencer) begin
        slot_v_r <= '0;
        step_r <= 2'd0;
        fetch_ready_r <= 1'b0;
      end else if (take) begin
        slot_v_r <= dec_ok;
        fetch_ready_r <= ~|dec_ok;
        slot_pred_r <= fetch_pred_target;
        for (int k = 0; k < NUM_DEC; k++) begin
          slot_op_r[k] <= dec_op[k];
          slot_rg_r[k] <= dec_rg[k];
          slot_ft_r[k] <= dec_ft[k];
        end
      end else if (emit) begin
        step_r <= last ? 2'd0 : step_r + 2'd1;
        if (last) begin
          slot_v_r[cur] <= 1'b0;
          fetch_ready_r <= (slot_v_r & ~(3'b001 << cur)) == 3'b000;
        end
      end else if (slot_v_r == '0) begin
        // after a flush nothing is left to expand, so fetch reopens
        fetch_ready_r <= 1'b1;
      end
    end
  end

  // pool entries
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < POOL_DEPTH; i++) begin
        p_valid_r[i] <= 1'b0;
        p_done_r[i] <= 1'b0;
        p_disp_r[i] <= 1'b0;
        p_susp_r[i] <= 1'b0;
        p_wake_r[i] <= 1'b0;
        p_a_rdy_r[i] <= 1'b0;
        p_b_rdy_r[i] <= 1'b0;
        p_dst_v_r[i] <= 1'b0;
        p_kind_r[i] <= UK_ALU;
        p_ldst_r[i] <= '0;
        p_width_r[i] <= 2'd0;
        p_a_tag_r[i] <= '0;
        p_b_tag_r[i] <= '0;
        p_a_val_r[i] <= '0;
        p_b_val_r[i] <= '0;
        p_res_r[i] <= '0;
        p_ft_r[i] <= '0;
        p_pred_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < POOL_DEPTH; i++) begin
        p_wake_r[i] <= 1'b0;
        if (mem_retry) begin
          p_susp_r[i] <= 1'b0;
        end
        for (int p = 0; p < NUM_PORTS; p++) begin
          if (wb_valid[p] && p_valid_r[i] &&
              !(ukind_t'(p) == UK_LD && wb_blocked)) begin
            if (!p_a_rdy_r[i] && p_a_tag_r[i] == wb_tag[p]) begin
              p_a_rdy_r[i] <= 1'b1;
              p_a_val_r[i] <= wb_data[p];
              p_wake_r[i] <= 1'b1;
            end
            if (!p_b_rdy_r[i] && p_b_tag_r[i] == wb_tag[p]) begin
              p_b_rdy_r[i] <= 1'b1;
              p_b_val_r[i] <= wb_data[p];
              p_wake_r[i] <= 1'b1;
            end
          end
        end
        // younger than a mispredicted branch: removed
        if (microcode_sequencer && pidx_t'(4'(i) - head_r[3:0]) > br_off) begin
          p_valid_r[i] <= 1'b0;
        end
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (wb_valid[p] && p_valid_r[wb_tag[p]]) begin
          if (ukind_t'(p) == UK_LD && wb_blocked) begin
            p_disp_r[wb_tag[p]] <= 1'b0;
            p_susp_r[wb_tag[p]] <= 1'b1;
          end else begin
            p_done_r[wb_tag[p]] <= 1'b1;
            p_res_r[wb_tag[p]] <= wb_data[p];
          end
        end
        if (gnt_v[p]) begin
          p_disp_r[gnt_idx[p]] <= 1'b1;
        end
      end
      for (int r = 0; r < RET_WIDTH; r++) begin
        if (2'(r) < ret_cnt) begin
          p_valid_r[ret_idx[r]] <= 1'b0;
        end
      end
      if (emit) begin
        p_valid_r[tail_r[3:0]] <= 1'b1;
        p_done_r[tail_r[3:0]] <= 1'b0;
        p_disp_r[tail_r[3:0]] <= 1'b0;
        p_susp_r[tail_r[3:0]] <= 1'b0;
        p_kind_r[tail_r[3:0]] <= uk;
        p_dst_v_r[tail_r[3:0]] <= has_dst;
        p_ldst_r[tail_r[3:0]] <= slot_rg_r[cur][RG_DST_LSB +: 3];
        p_width_r[tail_r[3:0]] <= slot_rg_r[cur][RG_WIDTH_LSB +: 2];
        p_a_rdy_r[tail_r[3:0]] <= res_a[20] | ~need_a;
        p_a_tag_r[tail_r[3:0]] <= res_a[19:16];
        p_a_val_r[tail_r[3:0]] <= res_a[15:0];
        p_b_rdy_r[tail_r[3:0]] <= res_b[20] | ~need_b;
        p_b_tag_r[tail_r[3:0]] <= res_b[19:16];
        p_b_val_r[tail_r[3:0]] <= res_b[15:0];
        p_ft_r[tail_r[3:0]] <= slot_ft_r[cur];
        p_pred_r[tail_r[3:0]] <= slot_pred_r;
      end
    end
  end

  // pointers, rename table, committed registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      head_r <= '0;
      tail_r <= '0;
      retire_count_r <= 2'd0;
    end else begin
      head_r <= head_r + 5'(ret_cnt);
      tail_r <= microcode_sequencer ? head_r + 5'(br_off) + 5'h01 : tail_r + 5'(emit);
      retire_count_r <= ret_cnt;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int j = 0; j < LREGS; j++) begin
        map_valid_r[j] <= 1'b0;
        map_tag_r[j] <= '0;
      end
    end else if (microcode_sequencer) begin
      // rebuilt from survivors that are not leaving this clock
      for (int j = 0; j < LREGS; j++) begin
        map_valid_r[j] <= 1'b0;
      end
      for (int i = 0; i < POOL_DEPTH; i++) begin
        if (i >= int'(ret_cnt) && 4'(i) <= br_off &&
            p_dst_v_r[head_r[3:0] + 4'(i)]) begin
          map_valid_r[p_ldst_r[head_r[3:0] + 4'(i)]] <= 1'b1;
          map_tag_r[p_ldst_r[head_r[3:0] + 4'(i)]] <= head_r[3:0] + 4'(i);
        end
      end
    end else begin
      for (int r = 0; r < RET_WIDTH; r++) begin
        if (2'(r) < ret_cnt && p_dst_v_r[ret_idx[r]] &&
            map_tag_r[p_ldst_r[ret_idx[r]]] == ret_idx[r]) begin
          map_valid_r[p_ldst_r[ret_idx[r]]] <= 1'b0;
        end
      end
      if (emit && has_dst) begin
        map_valid_r[slot_rg_r[cur][RG_DST_LSB +: 3]] <= 1'b1;
        map_tag_r[slot_rg_r[cur][RG_DST_LSB +: 3]] <= tail_r[3:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int j = 0; j < LREGS; j++) begin
        arch_r[j] <= '0;
      end
      dbg_val_r <= '0;
    end else begin
      for (int r = 0; r < RET_WIDTH; r++) begin
        if (2'(r) < ret_cnt && p_dst_v_r[ret_idx[r]]) begin
          arch_r[p_ldst_r[ret_idx[r]]] <= p_res_r[ret_idx[r]];
        end
      end
      dbg_val_r <= arch_r[dbg_reg];
    end
  end

  // dispatch, redirect and store outputs
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      disp_valid_r <= '0;
      disp_tag_r <= '0;
      disp_a_r <= '0;
      disp_b_r <= '0;
      disp_width_r <= '0;
      redirect_valid_r <= 1'b0;
      redirect_target_r <= '0;
      mem_st_valid_r <= 1'b0;
      mem_st_addr_r <= '0;
      mem_st_data_r <= '0;
      mem_st_width_r <= 2'd0;
      st_addr_r <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        disp_valid_r[p] <= gnt_v[p];
        disp_tag_r[p] <= gnt_idx[p];
        disp_a_r[p] <= p_a_val_r[gnt_idx[p]];
        disp_b_r[p] <= p_b_val_r[gnt_idx[p]];
        disp_width_r[p] <= p_width_r[gnt_idx[p]];
      end
      redirect_valid_r <= microcode_sequencer;
      redirect_target_r <= br_actual;
      // stores leave only at retirement, hence in order and non-speculative
      mem_st_valid_r <= ret_std;
      if (ret_sta) begin
        st_addr_r <= p_res_r[ret_last];
      end
      if (ret_std) begin
        mem_st_addr_r <= st_addr_r;
        mem_st_data_r <= p_res_r[ret_last];
        mem_st_width_r <= p_width_r[ret_last];
      end
    end
  end
endmodule

// file: core/ooo_core_pkg.sv
// constants and types shared by the out-of-order core control files
package ooo_core_pkg;
  localparam int FETCH_BYTES = 16;
  localparam int NUM_DEC = 3;
  localparam int NUM_PORTS = 5;
  localparam int RET_WIDTH = 3;
  localparam int POOL_DEPTH = 16;
  localparam int LREGS = 8;
  localparam int DATA_W = 16;
  localparam logic [DATA_W-1:0] INSTR_LEN = 16'h0002;
  // opcode byte: kind, extra count, second source
  localparam int OP_KIND_LSB = 5;
  localparam int OP_CNT_LSB = 3;
  localparam int OP_SRC2_LSB = 0;
  // register byte: width, destination, first source
  localparam int RG_WIDTH_LSB = 6;
  localparam int RG_DST_LSB = 3;
  localparam int RG_SRC1_LSB = 0;
  // instruction kinds
  localparam logic [2:0] IK_ALU = 3'h0;
  localparam logic [2:0] IK_BR = 3'h1;
  localparam logic [2:0] IK_LD = 3'h2;
  localparam logic [2:0] IK_ST = 3'h3;
  localparam logic [2:0] IK_CPLX = 3'h4;
  // micro-operation kinds, equal to the issue port number
  localparam logic [2:0] UK_ALU = 3'h0;
  localparam logic [2:0] UK_BR = 3'h1;
  localparam logic [2:0] UK_LD = 3'h2;
  localparam logic [2:0] UK_STA = 3'h3;
  localparam logic [2:0] UK_STD = 3'h4;
  // microcode word: {last, kind}; four sequences of up to four steps
  localparam int MC_ADDR_W = 4;
  localparam int MC_WORD_W = 4;
  localparam int MC_LAST_BIT = 3;
  localparam logic [63:0] MC_ROM_IMAGE = 64'h9999_8000_C302_8802;
  localparam logic [MC_WORD_W-1:0] MC_WORD_RST = 4'h0;
  localparam logic FETCH_READY_RST = 1'b1;
  localparam logic [4:0] POOL_FULL = 5'h10;
  typedef logic [3:0] pidx_t;
  typedef logic [4:0] ptr_t;
  typedef logic [DATA_W-1:0] word_t;
  typedef logic [2:0] lreg_t;
  typedef logic [2:0] ukind_t;
endpackage

// file: testbench/exec_model.sv
// execution ports: answer each dispatch one or two cycles later
module exec_model import ooo_core_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic [NUM_PORTS-1:0] disp_valid_r,
  input wire logic [NUM_PORTS-1:0][3:0] disp_tag_r,
  input wire logic [NUM_PORTS-1:0][DATA_W-1:0] disp_a_r,
  input wire logic [NUM_PORTS-1:0][DATA_W-1:0] disp_b_r,
  input wire logic redirect_valid_r,
  output logic [NUM_PORTS-1:0] wb_valid,
  output logic [NUM_PORTS-1:0][3:0] wb_tag,
  output logic [NUM_PORTS-1:0][DATA_W-1:0] wb_data,
  output logic wb_br_taken
);
  logic [NUM_PORTS-1:0] v1, v2;
  logic [NUM_PORTS-1:0][3:0] t1, t2;
  logic [NUM_PORTS-1:0][DATA_W-1:0] res, d1, d2;
  logic k1, k2;
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      res[p] = disp_a_r[p] | disp_b_r[p];
      wb_data[p] = (slow ? d2[p] : d1[p]) ^ {DATA_W{~wb_valid[p]}};
    end
    res[0] = disp_a_r[0] + disp_b_r[0] + 16'h0001;
    res[1] = (disp_a_r[1] | disp_b_r[1]) + 16'h0040;
    // load data is the address under a fixed pattern
    res[2] = disp_a_r[2] ^ 16'h5A5A;
    // store halves carry only their own operand
    res[3] = disp_a_r[3];
    res[4] = disp_b_r[4];
  end
  // squash drops all in flight: safe only with nothing older running
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      v1 <= '0;
      v2 <= '0;
    end else begin
      v1 <= redirect_valid_r ? '0 : disp_valid_r;
      v2 <= redirect_valid_r ? '0 : v1;
    end
  end
  always_ff @(posedge ref_clk) begin
    t1 <= disp_tag_r;
    t2 <= t1;
    d1 <= res;
    d2 <= d1;
    k1 <= ~(disp_a_r[1][0] | disp_b_r[1][0]);
    k2 <= k1;
  end
  assign wb_valid = (slow ? v2 : v1) & ~{NUM_PORTS{redirect_valid_r}};
  assign wb_tag = slow ? t2 : t1;
  assign wb_br_taken = slow ? k2 : k1;
endmodule

// file: testbench/ooo_core_chk.sv
// port checker for the out-of-order core control block
module ooo_core_chk import ooo_core_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic fetch_valid,
  input wire logic [FETCH_BYTES-1:0] fetch_start,
  input wire logic [FETCH_BYTES-1:0] fetch_end,
  input wire logic fetch_ready_r,
  input wire logic [NUM_PORTS-1:0] port_free,
  input wire logic [NUM_PORTS-1:0] disp_valid_r,
  input wire logic [NUM_PORTS-1:0] wb_valid,
  input wire logic redirect_valid_r,
  input wire logic mem_st_ready,
  input wire logic mem_st_valid_r,
  input wire logic [1:0] retire_count_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_disp_port_free: assert property (
    (disp_valid_r & ~$past(port_free)) == 5'h00) else $error("busy port hit");
  a_store_mem_ready: assert property (
    mem_st_valid_r |-> $past(mem_st_ready)) else $error("store not taken");
  a_store_at_retire: assert property (
    mem_st_valid_r |-> retire_count_r != 2'h0) else $error("store early");
  a_redirect_cause: assert property (
    redirect_valid_r |-> $past(wb_valid[1])) else $error("stray redirect");
  a_redirect_refetch: assert property (
    redirect_valid_r |-> !fetch_ready_r ##1 fetch_ready_r)
    else $error("fetch not restarted");
  a_fetch_taken: assert property (
    fetch_valid && fetch_ready_r && fetch_start[0] && fetch_end[1]
    |=> !fetch_ready_r) else $error("block not taken");
  a_ready_idle_hold: assert property (
    fetch_ready_r && !fetch_valid && !wb_valid[1] |=> fetch_ready_r)
    else $error("ready dropped idle");
  a_ready_returns: assert property (
    $fell(fetch_ready_r) |-> ##[1:200] fetch_ready_r)
    else $error("fetch stuck");
endmodule
bind ooo_core ooo_core_chk chk (.ref_clk, .sys_rst, .fetch_valid,
  .fetch_start, .fetch_end, .fetch_ready_r, .port_free, .disp_valid_r,
  .wb_valid, .redirect_valid_r, .mem_st_ready, .mem_st_valid_r,
  .retire_count_r);

// file: testbench/ooo_core_test.sv
// self-checking bench: random programs through decode to retirement
module ooo_core_test import ooo_core_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, sys_rst = 1'b1, fetch_valid = 1'b0, slow = 1'b0;
  logic [FETCH_BYTES-1:0][7:0] fetch_bytes = '0;
  logic [FETCH_BYTES-1:0] fetch_start = '0, fetch_end = '0;
  logic [DATA_W-1:0] fetch_pc = '0, fetch_pred_target = '0;
  logic [NUM_PORTS-1:0] port_free = '0;
  logic mem_st_ready = 1'b0, wb_blocked = 1'b0, mem_retry = 1'b0;
  logic [2:0] dbg_reg = '0;
  logic fetch_ready_r, wb_br_taken, redirect_valid_r, mem_st_valid_r;
  logic [NUM_PORTS-1:0] disp_valid_r, wb_valid;
  logic [NUM_PORTS-1:0][3:0] disp_tag_r, wb_tag;
  logic [NUM_PORTS-1:0][DATA_W-1:0] disp_a_r, disp_b_r, wb_data;
  logic [DATA_W-1:0] redirect_target_r, mem_st_addr_r, mem_st_data_r;
  logic [DATA_W-1:0] dbg_val_r;
  logic [1:0] mem_st_width_r, retire_count_r;
  logic [31:0] lf = 32'h6B391F3E;
  logic [DATA_W-1:0] rv [8];
  logic [33:0] rq[$], sq[$];
  int failures = 0, checks = 0;
  ooo_core uut (.ref_clk, .sys_rst, .fetch_valid, .fetch_bytes, .fetch_start,
    .fetch_end, .fetch_pc, .fetch_pred_target, .fetch_ready_r, .port_free,
    .disp_valid_r, .disp_tag_r, .disp_a_r, .disp_b_r, .disp_width_r(),
    .wb_valid, .wb_tag, .wb_data, .wb_br_taken, .wb_blocked,
    .mem_retry, .redirect_valid_r, .redirect_target_r, .mem_st_ready,
    .mem_st_valid_r, .mem_st_addr_r, .mem_st_data_r, .mem_st_width_r,
    .retire_count_r, .dbg_reg, .dbg_val_r);
  exec_model em (.ref_clk, .sys_rst, .slow, .disp_valid_r, .disp_tag_r,
    .disp_a_r, .disp_b_r, .redirect_valid_r, .wb_valid, .wb_tag, .wb_data,
    .wb_br_taken);
  always #20 ref_clk = ~ref_clk;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] rg(input logic [2:0] x);
    return (x == 3'h7) ? 3'h1 : x;
  endfunction
  always @(posedge ref_clk) begin
    lf <= nx(lf);
    port_free <= lf[4:0];
    mem_st_ready <= lf[7];
    wb_blocked <= lf[9] & lf[10];
    mem_retry <= lf[12];
  end
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // an empty queue yields all ones so an unexpected result never matches
  always @(negedge ref_clk) begin
    if (redirect_valid_r === 1'b1)
      chk({18'h0, redirect_target_r}, rq.size() ? rq.pop_front() : '1);
    if (mem_st_valid_r === 1'b1)
      chk({mem_st_width_r, mem_st_addr_r, mem_st_data_r},
        sq.size() ? sq.pop_front() : '1);
  end
  task automatic blk(input logic [2:0][15:0] ins, input logic [15:0] ip,
    input logic [15:0] pred);
    @(posedge ref_clk);
    fetch_valid <= 1'b1;
    fetch_bytes <= {80'h0, ins};
    fetch_start <= 16'h0015;
    fetch_end <= 16'h002A;
    fetch_pc <= ip;
    fetch_pred_target <= pred;
    do @(negedge ref_clk); while (fetch_ready_r !== 1'b1);
    @(posedge ref_clk);
    fetch_valid <= 1'b0;
    fetch_bytes <= ~fetch_bytes;
  endtask
  task automatic settle;
    int q;
    q = 0;
    for (int t = 0; t < 2000 && q < 16; t++) begin
      @(negedge ref_clk);
      q = (fetch_ready_r && disp_valid_r == 0 && wb_valid == 0 &&
        retire_count_r == 0) ? q + 1 : 0;
    end
    if (q < 16) failures++;
  endtask
  initial begin : main
    logic [31:0] s;
    logic [2:0][15:0] ins;
    logic [15:0] v, act, pred, ip;
    logic [2:0] k, d, a, b, x;
    logic [1:0] c;
    logic kill;
    rv = '{default: '0};
    ip = 16'h0100;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    s = lf;
    for (int ph = 0; ph < 2; ph++) begin
      slow <= ph[0];
      for (int j = 0; j < 12; j++) begin
        kill = 1'b0;
        pred = 16'h0000;
        for (int i = 0; i < 3; i++) begin
          s = nx(nx(nx(s)));
          k = (i == 0 && s[9]) ? IK_BR : ((s[8] & s[7]) ? IK_ST :
            ((s[8] & s[6]) ? IK_LD : IK_ALU));
          a = rg(s[2:0]);
          b = rg(s[5:3]);
          d = rg(s[12:10]);
          c = s[14:13];
          // one source register keeps the check blind to operand slots
          if (k == IK_BR || k == IK_ST) begin
            b = a;
            d = 3'h7;
            c = 2'h0;
          end
          // microcode sequence 2 is four alu steps, modelled as count 3
          x = (k == IK_ALU && c == 2'h3 && s[17]) ? IK_CPLX : k;
          ins[i] = {s[16:15], d, a, x, (x == IK_CPLX) ? 2'h2 : c, b};
          v = rv[a] | rv[b];
          if (kill) continue;
          if (k == IK_ALU) repeat (c + 1) rv[d] = rv[a] + rv[b] + 16'h1;
          else if (k == IK_LD) repeat (c + 1) rv[d] = rv[a] ^ 16'h5A5A;
          else if (k == IK_ST) sq.push_back({s[16:15], v, v});
          else begin
            act = v[0] ? ip + 16'h2 : v + 16'h40;
            pred = s[20] ? act : act ^ 16'h0100;
            if (pred != act) rq.push_back({18'h0, act});
            kill = (pred != act);
          end
        end
        if (ins[0][7:5] == IK_BR) settle();
        blk(ins, ip, pred);
        if (kill) settle();
        ip = kill ? act : ip + 16'h6;
      end
      settle();
      for (int r = 0; r < 7; r++) begin
        @(posedge ref_clk);
        dbg_reg <= r[2:0];
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({18'h0, dbg_val_r}, {18'h0, rv[r]});
      end
      $display("phase %0d done", ph);
    end
    chk(34'(rq.size() + sq.size()), 34'h0);
    close_out();
  end
  initial begin
    #800000;
    failures++;
    close_out();
  end
endmodule
